// *** rtl/ptcf_regs.vh ***
// Constants for the packet trunk cell framer.
// Assumes inclusion by bare name from the framer module and the bench.
`ifndef PTCF_REGS_VH
`define PTCF_REGS_VH

// ----------------------------------------
// Cell and unit geometry
// ----------------------------------------
`define PTCF_CELL_BITS 8'd192
`define PTCF_UNIT_BITS 8'd32
`define PTCF_CELL_LAST 5'd23
`define PTCF_UNIT_LAST 5'd3
`define PTCF_CRC_IDX 5'd2

// ----------------------------------------
// Header check and fill codes
// ----------------------------------------
`define PTCF_FILL 8'hFF
`define PTCF_CRC_POLY 8'h07
`define PTCF_CRC_INIT 8'h00
`define PTCF_IDLE_B1_0 8'h11
`define PTCF_IDLE_B1_1 8'h22
`define PTCF_IDLE_B1_2 8'h44
`define PTCF_IDLE_B1_3 8'h88
`define PTCF_ALRM_B1_0 8'hA1
`define PTCF_ALRM_B1_1 8'hA2
`define PTCF_ALRM_B1_2 8'hA4
`define PTCF_ALRM_B1_3 8'hA8
`define PTCF_IDLE_B3 8'h55
`define PTCF_ALRM_B3 8'hAA

// ----------------------------------------
// Reset values
// ----------------------------------------
`define PTCF_RST_LOSS 1'b1
`define PTCF_RST_BYTE 8'h00

`endif

// *** rtl/ptcf_framer.v ***
// Packet trunk cell framer: bit-serial transmit and receive sides.
// Assumes line bit slots arrive as strobes from pins of another domain.
//
// Functional notes
// - A cell may begin at any octet of a framed line, unrelated to line frames.
// - On unframed or subrate lines a cell may begin at any bit position.
// - A cell opens with a two-octet address, a header CRC octet and a type octet.
// - Alignment is found by searching for a four-octet window whose third octet is a valid CRC.
// - With no cell waiting, the transmitter sends a four-octet idle unit.
// - Idle units rotate through four distinct codes in fixed order.
// - Each idle code starts with FF and has a valid CRC in its third octet.
// - Losing the CRC at expected positions raises a loss-of-alignment alarm.
// - While receive has failed, the transmitter sends remote-alarm codes.
// - Four remote-alarm codes exist, each starting with FF with a valid CRC in octet three.
// - Idle and remote-alarm units are dropped, never forwarded as traffic.
// - Alignment ignores line framing so any line type works unchanged.
// - A data cell is 192 bits, 24 octets, in consecutive user bit positions.
`timescale 1ns/1ps
`default_nettype none
`include "ptcf_regs.vh"

module ptcf_framer (
    input wire clk,
    input wire resetn,
    input wire rx_line_bit,
    input wire rx_line_strobe,
    input wire tx_line_strobe,
    input wire [3:0] cfg_align_hits,
    input wire [3:0] cfg_loss_misses,
    input wire [7:0] tx_byte,
    input wire tx_cell_avail,
    output reg tx_line_bit_q,
    output reg tx_byte_take_q,
    output reg rx_bit_q,
    output reg rx_bit_valid_q,
    output reg rx_cell_first_q,
    output reg rx_loss_alarm_q,
    output reg rx_remote_alarm_q
);

    // ----------------------------------------
    // Local codes
    // ----------------------------------------
    localparam ST_HUNT = 2'd0;
    localparam ST_PRE = 2'd1;
    localparam ST_SYNC = 2'd2;
    localparam K_IDLE = 2'd0;
    localparam K_ALRM = 2'd1;
    localparam K_DATA = 2'd2;

    // Header CRC over the two leading octets, msb first
    function [7:0] ptcf_crc;
        input [15:0] d;
        integer i;
        reg [7:0] c;
        begin
            c = `PTCF_CRC_INIT;
            for (i = 15; i >= 0; i = i - 1) begin
                if (c[7] ^ d[i])
                    c = {c[6:0], 1'b0} ^ `PTCF_CRC_POLY;
                else
                    c = {c[6:0], 1'b0};
            end
            ptcf_crc = c;
        end
    endfunction
    // Second octet of idle or alarm code number idx
    function [7:0] ptcf_code_b1;
        input alarm;
        input integer idx;
        begin
            case (idx)
                0: ptcf_code_b1 = alarm ? `PTCF_ALRM_B1_0 : `PTCF_IDLE_B1_0;
                1: ptcf_code_b1 = alarm ? `PTCF_ALRM_B1_1 : `PTCF_IDLE_B1_1;
                2: ptcf_code_b1 = alarm ? `PTCF_ALRM_B1_2 : `PTCF_IDLE_B1_2;
                default: ptcf_code_b1 = alarm ? `PTCF_ALRM_B1_3 : `PTCF_IDLE_B1_3;
            endcase
        end
    endfunction
    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    reg rxb_m_q, rxb_s_q;
    reg rxs_m_q, rxs_s_q, rxs_p_q;
    reg txs_m_q, txs_s_q, txs_p_q;
    wire rx_stb;
    wire tx_stb;
    // Two flops on the bit pin, three on each strobe; the edge detect compares the second and third stages
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rxb_m_q <= 1'b0;
            rxb_s_q <= 1'b0;
            rxs_m_q <= 1'b0;
            rxs_s_q <= 1'b0;
            rxs_p_q <= 1'b0;
            txs_m_q <= 1'b0;
            txs_s_q <= 1'b0;
            txs_p_q <= 1'b0;
        end else begin
            rxb_m_q <= rx_line_bit;
            rxb_s_q <= rxb_m_q;
            rxs_m_q <= rx_line_strobe;
            rxs_s_q <= rxs_m_q;
            rxs_p_q <= rxs_s_q;
            txs_m_q <= tx_line_strobe;
            txs_s_q <= txs_m_q;
            txs_p_q <= txs_s_q;
        end
    end

    assign rx_stb = rxs_s_q & ~rxs_p_q;
    assign tx_stb = txs_s_q & ~txs_p_q;
    // ----------------------------------------
    // Receive window and header check
    // ----------------------------------------
    reg [31:0] sh_q;
    wire [31:0] sh_d;
    wire hdr_ok;
    wire is_fill;
    wire [3:0] idle_m;
    wire [3:0] alrm_m;
    wire is_idle;
    wire is_alrm;
    wire is_data;
    wire [7:0] len_last;
    // Window slides one bit per slot, so any bit offset is found
    assign sh_d = {sh_q[30:0], rxb_s_q};
    assign hdr_ok = sh_d[15:8] == ptcf_crc(sh_d[31:16]);
    assign is_fill = sh_d[31:24] == `PTCF_FILL;
    // Compare against each of the four idle and alarm codes
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_code
            assign idle_m[g] = sh_d[23:16] == ptcf_code_b1(1'b0, g);
            assign alrm_m[g] = sh_d[23:16] == ptcf_code_b1(1'b1, g);
        end
    endgenerate
    assign is_idle = is_fill & (|idle_m);
    assign is_alrm = is_fill & (|alrm_m);
    assign is_data = ~is_idle & ~is_alrm;
    // Short units are 32 bits, cells 192
    assign len_last = is_data ? (`PTCF_CELL_BITS - 8'd1) : (`PTCF_UNIT_BITS - 8'd1);

    // ----------------------------------------
    // Receive alignment state machine
    // ----------------------------------------
    reg [1:0] st_q;
    reg [7:0] cnt_q;
    reg [3:0] hits_q;
    reg [3:0] miss_q;
    reg fwd_q;
    wire [4:0] hits_inc;
    wire [4:0] miss_inc;

    assign hits_inc = {1'b0, hits_q} + 5'd1;
    assign miss_inc = {1'b0, miss_q} + 5'd1;
    // A threshold of zero behaves as one
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sh_q <= 32'h0000_0000;
            st_q <= ST_HUNT;
            cnt_q <= 8'h00;
            hits_q <= 4'h0;
            miss_q <= 4'h0;
            fwd_q <= 1'b0;
            rx_bit_q <= 1'b0;
            rx_bit_valid_q <= 1'b0;
            rx_cell_first_q <= 1'b0;
            rx_loss_alarm_q <= `PTCF_RST_LOSS;
            rx_remote_alarm_q <= 1'b0;
        end else if (rx_stb) begin
            sh_q <= sh_d;
            // The bit leaving the window is 32 slots old: the cell body
            rx_bit_q <= sh_q[31];
            rx_bit_valid_q <= fwd_q;
            rx_cell_first_q <= fwd_q && (cnt_q == `PTCF_CELL_BITS - 8'd1);
            case (st_q)
                ST_HUNT: begin
                    if (hdr_ok) begin
                        st_q <= ST_PRE;
                        hits_q <= 4'h1;
                        cnt_q <= len_last;
                    end
                end
                ST_PRE: begin
                    if (cnt_q != 8'h00) begin
                        cnt_q <= cnt_q - 8'd1;
                    end else if (!hdr_ok) begin
                        st_q <= ST_HUNT;
                    end else begin
                        hits_q <= hits_inc[3:0];
                        cnt_q <= len_last;
                        if (hits_inc >= {1'b0, cfg_align_hits}) begin
                            st_q <= ST_SYNC;
                            miss_q <= 4'h0;
                            rx_loss_alarm_q <= 1'b0;
                            fwd_q <= is_data;
                            rx_remote_alarm_q <= is_alrm;
                        end
                    end
                end
                ST_SYNC: begin
                    if (cnt_q != 8'h00) begin
                        cnt_q <= cnt_q - 8'd1;
                    end else if (hdr_ok) begin
                        miss_q <= 4'h0;
                        cnt_q <= len_last;
                        fwd_q <= is_data;
                        rx_remote_alarm_q <= is_alrm;
                    end else if (miss_inc >= {1'b0, cfg_loss_misses}) begin
                        st_q <= ST_HUNT;
                        fwd_q <= 1'b0;
                        rx_loss_alarm_q <= 1'b1;
                        rx_remote_alarm_q <= 1'b0;
                    end else begin
                        // Unverified unit: assume a cell length, drop its bits
                        miss_q <= miss_inc[3:0];
                        cnt_q <= `PTCF_CELL_BITS - 8'd1;
                        fwd_q <= 1'b0;
                    end
                end
                default: begin
                    st_q <= ST_HUNT;
                end
            endcase
        end else begin
            rx_bit_valid_q <= 1'b0;
            rx_cell_first_q <= 1'b0;
        end
    end

    // ----------------------------------------
    // Transmit unit selection
    // ----------------------------------------
    reg [2:0] tbit_q;
    reg [4:0] tidx_q;
    reg [1:0] tkind_q;
    reg [1:0] tsel_q;
    reg [1:0] idle_rot_q;
    reg [1:0] alrm_rot_q;
    reg [7:0] tsr_q;
    reg [7:0] tc0_q;
    reg [7:0] tc1_q;
    reg [1:0] kind_d;
    reg [1:0] sel_d;
    reg [7:0] nb_d;
    reg [7:0] cb1_d;
    wire tstart;
    wire [4:0] tlast;
    assign tstart = (tbit_q == 3'd0) && (tidx_q == 5'd0);
    assign tlast = (tkind_q == K_DATA) ? `PTCF_CELL_LAST : `PTCF_UNIT_LAST;
    // Choose the unit at its first bit; alarm outranks waiting cells
    always @* begin
        kind_d = tkind_q;
        sel_d = tsel_q;
        if (tstart) begin
            if (rx_loss_alarm_q) begin
                kind_d = K_ALRM;
                sel_d = alrm_rot_q;
            end else if (tx_cell_avail) begin
                kind_d = K_DATA;
            end else begin
                kind_d = K_IDLE;
                sel_d = idle_rot_q;
            end
        end
    end

    // Next octet; header CRC is regenerated so a bad user octet can't break framing
    always @* begin
        cb1_d = ptcf_code_b1(kind_d == K_ALRM, {30'd0, sel_d});
        nb_d = tx_byte;
        if (kind_d == K_DATA) begin
            if (tidx_q == `PTCF_CRC_IDX)
                nb_d = ptcf_crc({tc0_q, tc1_q});
        end else begin
            case (tidx_q)
                5'd0: nb_d = `PTCF_FILL;
                5'd1: nb_d = cb1_d;
                5'd2: nb_d = ptcf_crc({`PTCF_FILL, cb1_d});
                default: nb_d = (kind_d == K_ALRM) ? `PTCF_ALRM_B3 : `PTCF_IDLE_B3;
            endcase
        end
    end

    // ----------------------------------------
    // Transmit serialiser
    // ----------------------------------------
    // Octets leave msb first, one bit per line slot, back to back
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tbit_q <= 3'd0;
            tidx_q <= 5'd0;
            tkind_q <= K_IDLE;
            tsel_q <= 2'd0;
            idle_rot_q <= 2'd0;
            alrm_rot_q <= 2'd0;
            tsr_q <= `PTCF_RST_BYTE;
            tc0_q <= `PTCF_RST_BYTE;
            tc1_q <= `PTCF_RST_BYTE;
            tx_line_bit_q <= 1'b0;
            tx_byte_take_q <= 1'b0;
        end else if (tx_stb) begin
            tbit_q <= tbit_q + 3'd1;
            tx_byte_take_q <= (kind_d == K_DATA) && (tbit_q == 3'd0);
            if (tbit_q == 3'd0) begin
                tx_line_bit_q <= nb_d[7];
                tsr_q <= {nb_d[6:0], 1'b0};
                tkind_q <= kind_d;
                tsel_q <= sel_d;
                if (kind_d == K_DATA && tidx_q == 5'd0)
                    tc0_q <= tx_byte;
                if (kind_d == K_DATA && tidx_q == 5'd1)
                    tc1_q <= tx_byte;
                if (tstart && kind_d == K_IDLE)
                    idle_rot_q <= idle_rot_q + 2'd1;
                if (tstart && kind_d == K_ALRM)
                    alrm_rot_q <= alrm_rot_q + 2'd1;
            end else begin
                tx_line_bit_q <= tsr_q[7];
                tsr_q <= {tsr_q[6:0], 1'b0};
            end
            // Cells follow units with no gap, so a cell may start anywhere
            if (tbit_q == 3'd7)
                tidx_q <= (tidx_q == tlast) ? 5'd0 : tidx_q + 5'd1;
        end else begin
            tx_byte_take_q <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// *** verification/ptcf_framer_monitor.sv ***
// Checker for the trunk cell framer, bound to its ports.
// Assumes line strobes at least three clocks apart.
`timescale 1ns/1ps
`default_nettype none
module ptcf_framer_monitor (
    input wire logic clk,
    input wire logic resetn,
    input wire logic rx_line_strobe,
    input wire logic tx_line_strobe,
    input wire logic tx_cell_avail,
    input wire logic tx_line_bit_q,
    input wire logic tx_byte_take_q,
    input wire logic rx_bit_valid_q,
    input wire logic rx_cell_first_q,
    input wire logic rx_loss_alarm_q,
    input wire logic rx_remote_alarm_q
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // ----------------------------------------
    // Pulse spacing
    // ----------------------------------------
    // Octets and cells span many slots, so their pulses never cluster
    sequence s_no_first;
        (!rx_cell_first_q) [*8];
    endsequence
    sequence s_no_take;
        (!tx_byte_take_q) [*8];
    endsequence
    a_first_spaced: assert property (rx_cell_first_q |=> s_no_first)
        else $error("cell start pulses too close");
    a_take_spaced: assert property (tx_byte_take_q |=> s_no_take)
        else $error("octet take pulses too close");
    a_first_is_data: assert property (rx_cell_first_q |-> rx_bit_valid_q)
        else $error("cell start without a data bit");
    a_valid_one_cycle: assert property (rx_bit_valid_q |=> !rx_bit_valid_q)
        else $error("data bit pulse longer than a cycle");
    // ----------------------------------------
    // Ties between slots and outputs
    // ----------------------------------------
    a_valid_after_slot: assert property (rx_bit_valid_q |->
        $past(rx_line_strobe, 2) || $past(rx_line_strobe, 3))
        else $error("data bit without a line slot");
    a_loss_on_slot: assert property ($changed(rx_loss_alarm_q) |->
        $past(rx_line_strobe, 2) || $past(rx_line_strobe, 3))
        else $error("alignment state moved outside a slot");
    a_take_needs_cell: assert property (tx_byte_take_q |-> tx_cell_avail)
        else $error("octet taken with no cell waiting");
    a_tx_bit_holds: assert property ($rose(tx_line_strobe) |-> $stable(tx_line_bit_q) [*2])
        else $error("line bit moved at its sampling slot");
    a_remote_needs_align: assert property (rx_remote_alarm_q |-> !rx_loss_alarm_q)
        else $error("remote alarm flag while unaligned");
    a_reset_state: assert property ($rose(resetn) |->
        rx_loss_alarm_q && !rx_bit_valid_q && !tx_byte_take_q)
        else $error("wrong state after reset");
endmodule
bind ptcf_framer ptcf_framer_monitor u_mon (.clk(clk), .resetn(resetn),
    .rx_line_strobe(rx_line_strobe), .tx_line_strobe(tx_line_strobe),
    .tx_cell_avail(tx_cell_avail), .tx_line_bit_q(tx_line_bit_q),
    .tx_byte_take_q(tx_byte_take_q), .rx_bit_valid_q(rx_bit_valid_q),
    .rx_cell_first_q(rx_cell_first_q), .rx_loss_alarm_q(rx_loss_alarm_q),
    .rx_remote_alarm_q(rx_remote_alarm_q));
`default_nettype wire

// *** verification/ptcf_far_model.sv ***
// Far-end trunk node model: puts units on the line, records our line bits.
// Assumes the bench calls its tasks one at a time.
`timescale 1ns/1ps
`default_nettype none
module ptcf_far_model (
    input wire logic clk,
    input wire logic tx_line_bit_q,
    output logic rx_line_bit,
    output logic rx_line_strobe,
    output logic tx_line_strobe
);
    // Bits seen from the framer, one per slot, oldest first
    logic txq[$];
    initial begin
        rx_line_bit = 1'b0;
        rx_line_strobe = 1'b0;
        tx_line_strobe = 1'b0;
    end
    // Six-clock slot; the late sample leaves room for the framer's latency
    task automatic send_bit(input logic b);
        @(posedge clk);
        txq.push_back(tx_line_bit_q);
        rx_line_bit <= b;
        @(posedge clk);
        rx_line_strobe <= 1'b1;
        tx_line_strobe <= 1'b1;
        repeat (3) @(posedge clk);
        rx_line_strobe <= 1'b0;
        tx_line_strobe <= 1'b0;
        @(posedge clk);
    endtask
    // Units go out msb first with no tie to any line frame
    task automatic send_word(input logic [31:0] w);
        for (int i = 31; i >= 0; i--) send_bit(w[i]);
    endtask
    task automatic send_cell(input logic [191:0] c);
        for (int i = 191; i >= 0; i--) send_bit(c[i]);
    endtask
endmodule
`default_nettype wire

// *** verification/tb_top.sv ***
// Self-checking bench for the trunk cell framer against a queue model.
// Assumes the far-end model drives every line slot.
`timescale 1ns/1ps
`default_nettype none
`include "ptcf_regs.vh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin errors++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic tx_cell_avail = 1'b0;
    logic [7:0] tx_byte = 8'h00;
    logic [3:0] cfg_align_hits = 4'h3;
    logic [3:0] cfg_loss_misses = 4'h2;
    logic rx_line_bit, rx_line_strobe, tx_line_strobe, tx_line_bit_q, tx_byte_take_q;
    logic rx_bit_q, rx_bit_valid_q, rx_cell_first_q, rx_loss_alarm_q, rx_remote_alarm_q;
    int errors = 0;
    int n_compared = 0;
    int seed = 32'h62d7;
    int tk = 0;
    int rx_cnt = 0;
    logic exq[$];
    logic [7:0] cb[24];
    logic [191:0] txc;
    always #50 clk = ~clk;
    ptcf_framer dut (.clk(clk), .resetn(resetn), .rx_line_bit(rx_line_bit),
        .rx_line_strobe(rx_line_strobe), .tx_line_strobe(tx_line_strobe),
        .cfg_align_hits(cfg_align_hits), .cfg_loss_misses(cfg_loss_misses),
        .tx_byte(tx_byte), .tx_cell_avail(tx_cell_avail), .tx_line_bit_q(tx_line_bit_q),
        .tx_byte_take_q(tx_byte_take_q), .rx_bit_q(rx_bit_q), .rx_bit_valid_q(rx_bit_valid_q),
        .rx_cell_first_q(rx_cell_first_q), .rx_loss_alarm_q(rx_loss_alarm_q),
        .rx_remote_alarm_q(rx_remote_alarm_q));
    ptcf_far_model fp (.clk(clk), .tx_line_bit_q(tx_line_bit_q), .rx_line_bit(rx_line_bit),
        .rx_line_strobe(rx_line_strobe), .tx_line_strobe(tx_line_strobe));
    // ----------------------------------------
    // Reference model
    // ----------------------------------------
    function automatic logic [7:0] crc8(input logic [7:0] a, input logic [7:0] b);
        logic [15:0] d;
        logic [7:0] c;
        d = {a, b};
        c = `PTCF_CRC_INIT;
        for (int i = 15; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? `PTCF_CRC_POLY : 8'h00);
        return c;
    endfunction
    // Idle or remote-alarm unit number i of the rotation
    function automatic logic [31:0] unit(input logic alarm, input int i);
        logic [7:0] c;
        case (i)
            0: c = alarm ? `PTCF_ALRM_B1_0 : `PTCF_IDLE_B1_0;
            1: c = alarm ? `PTCF_ALRM_B1_1 : `PTCF_IDLE_B1_1;
            2: c = alarm ? `PTCF_ALRM_B1_2 : `PTCF_IDLE_B1_2;
            default: c = alarm ? `PTCF_ALRM_B1_3 : `PTCF_IDLE_B1_3;
        endcase
        return {`PTCF_FILL, c, crc8(`PTCF_FILL, c), alarm ? `PTCF_ALRM_B3 : `PTCF_IDLE_B3};
    endfunction
    // Searches the recorded line for the low n bits of pat
    function automatic int found(input logic [191:0] pat, input int n);
        logic [191:0] w;
        logic [191:0] m;
        w = '0;
        m = ~({192{1'b1}} << n);
        for (int i = 0; i < fp.txq.size(); i++) begin
            w = {w[190:0], fp.txq[i]};
            if (i >= n - 1 && ((w ^ pat) & m) === '0) return 1;
        end
        return 0;
    endfunction
    task automatic chk_units(input logic alarm);
        `CHK(found({64'h0, unit(alarm, 0), unit(alarm, 1), unit(alarm, 2), unit(alarm, 3)}, 128), 1)
    endtask
    task automatic send_units(input logic alarm, input int n);
        for (int k = 0; k < n; k++) fp.send_word(unit(alarm, k % 4));
    endtask
    // Random data cell with a good header; queued as expected traffic
    task automatic send_data_cell;
        logic [191:0] c;
        for (int i = 0; i < 6; i++) c = {c[159:0], 32'($random(seed))};
        c[191] = 1'b0;
        c[175:168] = crc8(c[191:184], c[183:176]);
        for (int i = 191; i >= 0; i--) exq.push_back(c[i]);
        fp.send_cell(c);
    endtask
    task automatic end_sim;
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // ----------------------------------------
    // Result checking and user cell feed
    // ----------------------------------------
    // Every forwarded bit must be the next queued one; empty queue reads unknown
    always @(posedge clk) if (rx_bit_valid_q === 1'b1) begin
        `CHK(rx_bit_q, exq[0])
        `CHK(rx_cell_first_q, rx_cnt % 192 == 0)
        if (exq.size() > 0) void'(exq.pop_front());
        rx_cnt++;
    end
    // Next octet follows each take; the cell is withdrawn after its last octet
    always @(posedge clk) if (tx_byte_take_q === 1'b1) begin
        tk <= tk + 1;
        tx_byte <= cb[(tk + 1) % 24];
        if (tk == 23) tx_cell_avail <= 1'b0;
    end
    initial begin
        repeat (40000) @(posedge clk);
        errors++;
        $display("watchdog expired");
        end_sim();
    end
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        repeat (2) @(posedge clk);
        `CHK(rx_loss_alarm_q, 1'b1)
        repeat (200) fp.send_bit(($random(seed) & 1) != 0);
        chk_units(1'b1);
        $display("test alarm_out done");
        repeat (($random(seed) & 7) + 1) fp.send_bit(1'b0);
        // Long run: a false hit left over from the random bits may cost a cell length
        send_units(1'b0, 24);
        `CHK(rx_loss_alarm_q, 1'b0)
        fp.txq.delete();
        // Eight units so a whole rotation fits whatever the transmit phase
        send_units(1'b0, 8);
        chk_units(1'b0);
        $display("test align_idle done");
        foreach (cb[i]) cb[i] = 8'($random(seed));
        cb[0][7] = 1'b0;
        tx_byte <= cb[0];
        tx_cell_avail <= 1'b1;
        repeat (3) send_data_cell();
        foreach (cb[i]) txc = {txc[183:0], (i == 2) ? crc8(cb[0], cb[1]) : cb[i]};
        `CHK(found(txc, 192), 1)
        `CHK(tk, 24)
        $display("test cells done");
        send_units(1'b1, 4);
        `CHK(rx_remote_alarm_q, 1'b1)
        `CHK(exq.size(), 0)
        $display("test remote done");
        repeat (4) fp.send_cell({192{1'b1}});
        `CHK(rx_loss_alarm_q, 1'b1)
        `CHK(rx_remote_alarm_q, 1'b0)
        fp.txq.delete();
        repeat (256) fp.send_bit(1'b1);
        chk_units(1'b1);
        $display("test loss done");
        end_sim();
    end
endmodule
`default_nettype wire
